// ===== hdl/ahb_regs.sv
// ahb-lite slave front end: latches the address phase, zero-wait access
// assumes a single master, single word transfers, OKAY response always
`timescale 1ns/1ps
module ahb_regs
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] addr_out
);
    logic pend_wr;
    logic [7:0] pend_addr;
    logic next_pend_wr;
    logic [7:0] next_pend_addr;
    logic take;

    // address phase accepted on nonseq or seq with hready
    assign take = hsel_in & hready_in & htrans_in[1];

    always_comb
    begin
        next_pend_wr = take & hwrite_in;
        next_pend_addr = take ? haddr_in[7:0] : pend_addr;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pend_wr <= 1'b0;
            pend_addr <= 8'h00;
        end
        else
        begin
            pend_wr <= next_pend_wr;
            pend_addr <= next_pend_addr;
        end
    end

    // reads decode straight off the address phase for zero wait
    assign wr_out = pend_wr;
    assign rd_out = take & ~hwrite_in;
    assign addr_out = wr_out ? pend_addr : haddr_in[7:0];
endmodule

// ===== hdl/periodic_timer.sv
// 10-bit periodic timer: single pulse output and capture input modes
// assumes one 50 MHz clock, asynchronous pins, ahb-lite register access
//
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ps

// What this block does
// - counter runs up to 3FF then wraps when period does not limit
// - pulse leading edge on low-to-high of counter_run, software writable
// - trigger pin active edge sets counter_run in single pulse mode
// - counter_run high starts counting and raises the output pulse
// - clearing counter_run ends the pulse
// - compare a match clears counter_run, ending the pulse
// - compare a match in single pulse raises the interrupt request
// - single pulse counter zeroes on counter_run rising or at the 3FF wrap, never on period match
// - period and clear source select unused in single pulse mode
// - capture source is capture pin or trigger pin by select bit
// - pin function picks rising, falling or both capture edges
// - pin function 11 disables capture, counter keeps running
// - capture mode counter starts on software counter_run rising
// - active edge copies counter into compare a and raises interrupt
// - capture counter free-runs until counter_run falls
// - period match resets counter and raises interrupt in capture mode
// - period zero lets the counter run to full count
// - capture mode ignores output controls and drives no output
module periodic_timer
    import ptimer_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic [2:0] hsize_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [31:0] hwdata_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic ext_clock_trigger_pin_in,
    input wire logic capture_input_pin_in,
    output logic pulse_out,
    output logic pulse_oe_out,
    output logic periodic_timer_irq_out
);
    import ptimer_pkg::*;

    ctrl_s ctrl;
    ctrl_s next_ctrl;
    logic [9:0] counter;
    logic [9:0] next_counter;
    logic [9:0] compare_a_value;
    logic [9:0] next_compare_a_value;
    logic [9:0] period_value;
    logic [9:0] next_period_value;
    logic run_prev;
    logic pulse;
    logic next_pulse;
    logic irq_a;
    logic irq_p;
    logic next_irq_a;
    logic next_irq_p;
    logic irq_pulse;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic wr;
    logic rd;
    logic [7:0] addr;
    edges_s trig_edges;
    edges_s cap_edges;
    edges_s src_edges;
    logic pulse_mode;
    logic capture_mode;
    logic run_rise;
    logic match_a;
    logic match_p;
    logic cap_hit;
    logic trig_hit;

    pin_edge_sync u_trig_sync
    (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .pin_in(ext_clock_trigger_pin_in),
        .edges_out(trig_edges),
        .level_out()
    );

    pin_edge_sync u_cap_sync
    (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .pin_in(capture_input_pin_in),
        .edges_out(cap_edges),
        .level_out()
    );

    ahb_regs u_bus
    (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .hsel_in(hsel_in),
        .haddr_in(haddr_in),
        .htrans_in(htrans_in),
        .hwrite_in(hwrite_in),
        .hready_in(hready_in),
        .wr_out(wr),
        .rd_out(rd),
        .addr_out(addr)
    );

    // mode decode and event detection
    assign pulse_mode = (ctrl.mode_sel == MODE_PULSE);
    assign capture_mode = (ctrl.mode_sel == MODE_CAPTURE);
    assign run_rise = ctrl.run & ~run_prev;
    assign match_a = ctrl.run & (counter == compare_a_value);
    // period zero falls through to a wrap at the top count
    assign match_p = ctrl.run & (period_value != CNT_RESET)
        & (counter == period_value);
    assign src_edges = ctrl.capt_src ? trig_edges : cap_edges;
    assign trig_hit = ctrl.trig_rising ? trig_edges.rise : trig_edges.fall;

    // capture edge choice, 11 means none
    always_comb
    begin
        case (ctrl.func_sel)
            EDGE_RISE: cap_hit = src_edges.rise;
            EDGE_FALL: cap_hit = src_edges.fall;
            EDGE_BOTH: cap_hit = src_edges.rise | src_edges.fall;
            EDGE_NONE: cap_hit = 1'b0;
            default: cap_hit = 1'b0;
        endcase
        cap_hit = cap_hit & capture_mode & ctrl.run;
    end

    // control register: bus writes, trigger set, compare a clear
    always_comb
    begin
        next_ctrl = ctrl;
        if (wr && addr == CTRL_OFS)
        begin
            next_ctrl = ctrl_s'(hwdata_in[9:0]);
        end
        if (pulse_mode && match_a)
        begin
            next_ctrl.run = 1'b0;
        end
        // a trigger edge in the same cycle wins over any clear
        if (pulse_mode && trig_hit)
        begin
            next_ctrl.run = 1'b1;
        end
    end

    // counter: zero on run rising, step while running, hold when stopped
    always_comb
    begin
        next_counter = counter;
        if (run_rise)
        begin
            next_counter = CNT_RESET;
        end
        else if (ctrl.run)
        begin
            if (capture_mode && match_p)
            begin
                next_counter = CNT_RESET;
            end
            else if (counter == CNT_MAX)
            begin
                next_counter = CNT_RESET;
            end
            else
            begin
                next_counter = 10'(counter + 10'h001);
            end
        end
    end

    // compare a: software writes, capture overwrites
    always_comb
    begin
        next_compare_a_value = compare_a_value;
        next_period_value = period_value;
        if (wr && addr == CMPA_OFS)
        begin
            next_compare_a_value = hwdata_in[9:0];
        end
        if (wr && addr == PER_OFS)
        begin
            next_period_value = hwdata_in[9:0];
        end
        if (cap_hit)
        begin
            next_compare_a_value = counter;
        end
    end

    // output pulse follows the new run and mode, so it rises with run
    always_comb
    begin
        next_pulse = (next_ctrl.mode_sel == MODE_PULSE) & next_ctrl.run;
    end

    // sticky flags: write one to clear, set wins over clear
    assign irq_pulse = (pulse_mode & match_a) | cap_hit;
    always_comb
    begin
        next_irq_a = irq_a;
        next_irq_p = irq_p;
        if (wr && addr == STAT_OFS)
        begin
            next_irq_a = irq_a & ~hwdata_in[IRQ_A_BIT];
            next_irq_p = irq_p & ~hwdata_in[IRQ_P_BIT];
        end
        if (irq_pulse)
        begin
            next_irq_a = 1'b1;
        end
        if (capture_mode && match_p)
        begin
            next_irq_p = 1'b1;
        end
    end

    // read mux off the address phase, unmapped reads as zero
    always_comb
    begin
        next_rdata = rdata;
        if (rd)
        begin
            case (haddr_in[7:0])
                CTRL_OFS: next_rdata = {22'h00_0000, ctrl};
                CMPA_OFS: next_rdata = {22'h00_0000, compare_a_value};
                PER_OFS: next_rdata = {22'h00_0000, period_value};
                STAT_OFS: next_rdata = {30'h0000_0000, irq_p, irq_a};
                CNT_OFS: next_rdata = {22'h00_0000, counter};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ctrl <= ctrl_s'(CTRL_RESET);
            counter <= CNT_RESET;
            compare_a_value <= CNT_RESET;
            period_value <= CNT_RESET;
            run_prev <= 1'b0;
            pulse <= 1'b0;
            irq_a <= 1'b0;
            irq_p <= 1'b0;
            rdata <= 32'h0000_0000;
        end
        else
        begin
            ctrl <= next_ctrl;
            counter <= next_counter;
            compare_a_value <= next_compare_a_value;
            period_value <= next_period_value;
            run_prev <= ctrl.run;
            pulse <= next_pulse;
            irq_a <= next_irq_a;
            irq_p <= next_irq_p;
            rdata <= next_rdata;
        end
    end

    // outputs
    assign hrdata_out = rdata;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign pulse_out = pulse;
    assign pulse_oe_out = pulse_mode;
    assign periodic_timer_irq_out = irq_a | irq_p;

    // checks
    property p_match_ends_run;
        @(posedge clk_in) disable iff (!reset_n_in)
        (pulse_mode && match_a && !trig_hit) |=> !ctrl.run;
    endproperty
    a_match_ends_run: assert property (p_match_ends_run)
        else $error("compare a match did not clear run");

    property p_trig_sets_run;
        @(posedge clk_in) disable iff (!reset_n_in)
        (pulse_mode && trig_hit) |=> ctrl.run;
    endproperty
    a_trig_sets_run: assert property (p_trig_sets_run)
        else $error("trigger edge did not set run");

    property p_rise_zeroes;
        @(posedge clk_in) disable iff (!reset_n_in)
        run_rise |=> counter == CNT_RESET;
    endproperty
    a_rise_zeroes: assert property (p_rise_zeroes)
        else $error("counter not zero after run rise");

    property p_step;
        @(posedge clk_in) disable iff (!reset_n_in)
        (ctrl.run && !run_rise && !match_p && counter != CNT_MAX)
        |=> counter == $past(counter) + 10'h001;
    endproperty
    a_step: assert property (p_step)
        else $error("counter did not advance");

    property p_hold;
        @(posedge clk_in) disable iff (!reset_n_in)
        (!ctrl.run && !run_prev) |=> $stable(counter);
    endproperty
    a_hold: assert property (p_hold)
        else $error("counter moved while stopped");

    property p_capture;
        @(posedge clk_in) disable iff (!reset_n_in)
        cap_hit |=> compare_a_value == $past(counter) && irq_a;
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture did not latch counter");

    property p_period;
        @(posedge clk_in) disable iff (!reset_n_in)
        (capture_mode && match_p && !run_rise) |=> counter == 10'h000 && irq_p;
    endproperty
    a_period: assert property (p_period)
        else $error("period match did not reset counter");

    property p_no_out;
        @(posedge clk_in) disable iff (!reset_n_in)
        capture_mode |-> !pulse_oe_out && !pulse_out;
    endproperty
    a_no_out: assert property (p_no_out)
        else $error("output driven in capture mode");

    property p_edge_none;
        @(posedge clk_in) disable iff (!reset_n_in)
        (ctrl.func_sel == EDGE_NONE) |-> !cap_hit;
    endproperty
    a_edge_none: assert property (p_edge_none)
        else $error("capture with edges disabled");
endmodule

// ===== hdl/pin_edge_sync.sv
// two-stage synchroniser with rise/fall detection for one pin
// assumes the pin is asynchronous to clk_in
`timescale 1ns/1ps
module pin_edge_sync
    import ptimer_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic pin_in,
    output ptimer_pkg::edges_s edges_out,
    output logic level_out
);
    logic meta;
    logic sync;
    logic prev;

    // first stage feeds only the second
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            meta <= pin_in;
            sync <= meta;
            prev <= sync;
        end
    end

    // edges from the settled stages
    always_comb
    begin
        edges_out.rise = sync & ~prev;
        edges_out.fall = ~sync & prev;
    end
    assign level_out = sync;
endmodule

// ===== hdl/ptimer_pkg.sv
// constants and carriers for the 10-bit periodic timer, pulse/capture modes
// assumes a single 50 MHz clock domain and an ahb-lite register bus
package ptimer_pkg;
    localparam int CNT_W = 10;
    localparam logic [9:0] CNT_MAX = 10'h3FF;
    localparam logic [9:0] CNT_RESET = 10'h000;
    // byte offsets of the registers
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CMPA_OFS = 8'h04;
    localparam logic [7:0] PER_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0C;
    localparam logic [7:0] CNT_OFS = 8'h10;
    // control field positions
    localparam int RUN_BIT = 0;
    localparam int MODE_LO_BIT = 1;
    localparam int FUNC_LO_BIT = 3;
    localparam int CAPTS_BIT = 5;
    localparam int CCLR_BIT = 6;
    localparam int OC_BIT = 7;
    localparam int POL_BIT = 8;
    localparam int TRIG_EDGE_BIT = 9;
    // status field positions
    localparam int IRQ_A_BIT = 0;
    localparam int IRQ_P_BIT = 1;
    // control reset value, mode codes and capture edge codes
    localparam logic [9:0] CTRL_RESET = 10'h000;
    localparam logic [1:0] MODE_CAPTURE = 2'b01;
    localparam logic [1:0] MODE_PULSE = 2'b10;
    localparam logic [1:0] EDGE_RISE = 2'b00;
    localparam logic [1:0] EDGE_FALL = 2'b01;
    localparam logic [1:0] EDGE_BOTH = 2'b10;
    localparam logic [1:0] EDGE_NONE = 2'b11;

    typedef struct packed {
        logic trig_rising;  // trigger pin active edge choice
        logic pol_invert;
        logic init_level;
        logic clr_sel;
        logic capt_src;
        logic [1:0] func_sel;
        logic [1:0] mode_sel;
        logic run;
    } ctrl_s;

    typedef struct packed {
        logic rise;
        logic fall;
    } edges_s;
endpackage

// ===== verification/periodic_timer_tb.sv
// self-checking bench for the periodic timer, pulse and capture modes
// assumes zero-wait ahb-lite slave and 2-flop synced pins
`timescale 1ns/1ps
module periodic_timer_tb;
    import ptimer_pkg::*;
    logic clk_in, reset_n_in, hsel_in, hwrite_in;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, q;
    logic [1:0] htrans_in;
    logic [2:0] hsize_in;
    logic hreadyout_out, hresp_out, pulse_out, pulse_oe_out, irq;
    logic trig, capt;
    int fails, comparisons, w;
    logic [1:0] ec [4] = '{EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_NONE};
    logic rx [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic fx [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

    periodic_timer i_periodic_timer (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
        .htrans_in(htrans_in), .hsize_in(hsize_in), .hwrite_in(hwrite_in),
        .hready_in(hreadyout_out), .hwdata_in(hwdata_in),
        .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out), .ext_clock_trigger_pin_in(trig),
        .capture_input_pin_in(capt), .pulse_out(pulse_out),
        .pulse_oe_out(pulse_oe_out), .periodic_timer_irq_out(irq));
    ptimer_pins i_ptimer_pins (.clk_in(clk_in), .trig_out(trig),
        .capt_out(capt));

    // 50 MHz clock
    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // compare and count
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // one ahb single word transfer, held until hready is sampled high
    task automatic ahb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_in);
        hsel_in <= 1'b1;
        haddr_in <= {24'h00_0000, a};
        htrans_in <= 2'b10;
        hsize_in <= 3'b010;
        hwrite_in <= wr;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'b00;
        hsel_in <= 1'b0;
        hwdata_in <= d;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        q = hrdata_out;
        // step past the edge so callers see the settled outputs
        #1;
    endtask

    // control word: trig edge, source, pin function, mode, run
    function automatic logic [31:0] cw(input logic run, input logic [1:0] m,
        input logic [1:0] f, input logic s, input logic t);
        return {22'h00_0000, t, 3'b001, s, f, m, run};
    endfunction

    // count cycles while the pulse stays high
    task automatic width();
        w = 0;
        #1;
        while (pulse_out === 1'b1 && w < 2000)
        begin
            @(posedge clk_in);
            #1;
            w++;
        end
    endtask

    // reset values and unmapped access
    task automatic t_reset();
        ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
        ahb(1'b0, 8'h20, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, q);
        ahb(1'b0, CTRL_OFS, 32'h0000_0000);
        chk("ctrl", 32'h0000_0000, q);
        ahb(1'b0, STAT_OFS, 32'h0000_0000);
        chk("status", 32'h0000_0000, q);
        ahb(1'b0, CNT_OFS, 32'h0000_0000);
        chk("counter", 32'h0000_0000, q);
        chk("oe", 32'h0000_0000, {31'h0, pulse_oe_out});
        chk("hresp", 32'h0000_0000, {31'h0, hresp_out});
        $display("test reset done");
    endtask

    // software started pulses, width set by compare a, twice in a row
    task automatic t_pulse();
        ahb(1'b1, PER_OFS, 32'h0000_0003);
        ahb(1'b1, CMPA_OFS, 32'h0000_0005);
        repeat (2)
        begin
            ahb(1'b1, CTRL_OFS, cw(1'b1, MODE_PULSE, EDGE_NONE, 1'b0,
                1'b0) | 32'h0000_0040);
            chk("oe", 32'h0000_0001, {31'h0, pulse_oe_out});
            width();
            chk("width", 32'h0000_0007, w);
            chk("irq", 32'h0000_0001, {31'h0, irq});
            ahb(1'b0, CTRL_OFS, 32'h0000_0000);
            chk("run cleared", 32'h0000_0000, {31'h0, q[RUN_BIT]});
            ahb(1'b1, STAT_OFS, 32'h0000_0003);
        end
        chk("irq clear", 32'h0000_0000, {31'h0, irq});
        $display("test pulse done");
    endtask

    // software clear ends the pulse early, no compare flag
    task automatic t_abort();
        ahb(1'b1, CMPA_OFS, 32'h0000_03FF);
        ahb(1'b1, CTRL_OFS, cw(1'b1, MODE_PULSE, EDGE_NONE, 1'b0, 1'b0));
        repeat (10) @(posedge clk_in);
        ahb(1'b1, CTRL_OFS, cw(1'b0, MODE_PULSE, EDGE_NONE, 1'b0, 1'b0));
        #1;
        chk("abort pulse", 32'h0000_0000, {31'h0, pulse_out});
        ahb(1'b0, STAT_OFS, 32'h0000_0000);
        chk("abort flag", 32'h0000_0000, q);
        $display("test abort done");
    endtask

    // trigger pin starts the pulse by setting run, rising then falling
    task automatic t_trig();
        ahb(1'b1, CMPA_OFS, 32'h0000_0028);
        ahb(1'b1, CTRL_OFS, cw(1'b0, MODE_PULSE, EDGE_NONE, 1'b0, 1'b1));
        i_ptimer_pins.set_trig(1'b1);
        repeat (6) @(posedge clk_in);
        #1;
        chk("trig pulse", 32'h0000_0001, {31'h0, pulse_out});
        ahb(1'b0, CTRL_OFS, 32'h0000_0000);
        chk("trig run", 32'h0000_0001, {31'h0, q[RUN_BIT]});
        width();
        chk("trig irq", 32'h0000_0001, {31'h0, irq});
        ahb(1'b1, STAT_OFS, 32'h0000_0003);
        ahb(1'b1, CTRL_OFS, cw(1'b0, MODE_PULSE, EDGE_NONE, 1'b0, 1'b0));
        i_ptimer_pins.set_trig(1'b0);
        repeat (6) @(posedge clk_in);
        #1;
        chk("fall trig pulse", 32'h0000_0001, {31'h0, pulse_out});
        width();
        ahb(1'b1, STAT_OFS, 32'h0000_0003);
        $display("test trigger done");
    endtask

    // every capture edge code on both sources, then period and wrap
    task automatic t_capture();
        // period zero keeps the period flag out of the capture checks
        ahb(1'b1, PER_OFS, 32'h0000_0000);
        for (int i = 0; i < 8; i++)
        begin
            ahb(1'b1, CTRL_OFS, 32'h0000_0000);
            ahb(1'b1, STAT_OFS, 32'h0000_0003);
            ahb(1'b1, CTRL_OFS, cw(1'b1, MODE_CAPTURE, ec[i % 4], i > 3,
                1'b0) | 32'h0000_0180);
            chk("cap oe", 32'h0000_0000, {31'h0, pulse_oe_out});
            if (i > 3) i_ptimer_pins.set_trig(1'b1);
            else i_ptimer_pins.set_capt(1'b1);
            repeat (8) @(posedge clk_in);
            ahb(1'b0, STAT_OFS, 32'h0000_0000);
            chk("cap rise", {31'h0, rx[i % 4]}, q);
            ahb(1'b1, STAT_OFS, 32'h0000_0003);
            if (i > 3) i_ptimer_pins.set_trig(1'b0);
            else i_ptimer_pins.set_capt(1'b0);
            repeat (8) @(posedge clk_in);
            ahb(1'b0, STAT_OFS, 32'h0000_0000);
            chk("cap fall", {31'h0, fx[i % 4]}, q);
            chk("cap pulse", 32'h0000_0000, {31'h0, pulse_out});
        end
        ahb(1'b0, CMPA_OFS, 32'h0000_0000);
        w = q;
        ahb(1'b0, CNT_OFS, 32'h0000_0000);
        chk("cap order", 32'h0000_0001, {31'h0, w < q && w > 0});
        ahb(1'b1, CTRL_OFS, 32'h0000_0000);
        ahb(1'b1, PER_OFS, 32'h0000_0014);
        ahb(1'b1, STAT_OFS, 32'h0000_0003);
        ahb(1'b1, CTRL_OFS, cw(1'b1, MODE_CAPTURE, EDGE_NONE, 1'b0, 1'b0));
        repeat (60) @(posedge clk_in);
        ahb(1'b0, STAT_OFS, 32'h0000_0000);
        chk("period flag", 32'h0000_0002, q);
        ahb(1'b0, CNT_OFS, 32'h0000_0000);
        chk("period cap", 32'h0000_0001, {31'h0, q <= 20});
        ahb(1'b1, CTRL_OFS, 32'h0000_0000);
        ahb(1'b1, PER_OFS, 32'h0000_0000);
        ahb(1'b1, CTRL_OFS, cw(1'b1, MODE_CAPTURE, EDGE_NONE, 1'b0, 1'b0));
        repeat (500) @(posedge clk_in);
        ahb(1'b0, CNT_OFS, 32'h0000_0000);
        chk("full run", 32'h0000_0001, {31'h0, q > 400});
        repeat (540) @(posedge clk_in);
        ahb(1'b0, CNT_OFS, 32'h0000_0000);
        chk("wrap", 32'h0000_0001, {31'h0, q < 64});
        $display("test capture done");
    endtask

    // verdict and end of run
    task automatic tally_and_finish();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // main sequence
    initial
    begin
        fails = 0;
        comparisons = 0;
        reset_n_in = 1'b0;
        hsel_in = 1'b0;
        haddr_in = 32'h0000_0000;
        htrans_in = 2'b00;
        hsize_in = 3'b000;
        hwrite_in = 1'b0;
        hwdata_in = 32'h0000_0000;
        repeat (20) @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_reset();
        t_pulse();
        t_abort();
        t_trig();
        t_capture();
        tally_and_finish();
    end

    // watchdog well beyond the expected run length
    initial
    begin
        #400us;
        fails++;
        tally_and_finish();
    end
endmodule

// ===== verification/ptimer_pins.sv
// far-side pin model: trigger pin and capture pin of the periodic timer
// assumes the caller picks levels; each change lands just after a clock edge
`timescale 1ns/1ps
module ptimer_pins
(
    input wire logic clk_in,
    output logic trig_out,
    output logic capt_out
);
    // both pins rest low until a scenario moves them
    initial
    begin
        trig_out = 1'b0;
        capt_out = 1'b0;
    end

    // trigger pin level, starts a pulse or feeds a capture
    task automatic set_trig(input logic v);
        @(posedge clk_in);
        trig_out <= v;
    endtask

    // capture pin level, the default capture source
    task automatic set_capt(input logic v);
        @(posedge clk_in);
        capt_out <= v;
    endtask
endmodule
